// ### core/pap_pkg.sv
// pap_pkg: register map, field layout, reset values and timing constants
// assumes: shared by the configuration register top and its helper modules
package pap_pkg;

  localparam int unsigned DATA_W     = 24;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned CURVE_W    = 8;
  localparam int unsigned EXACT_W    = 14;
  localparam int unsigned NDIV_W     = 19;

  // register offsets
  localparam logic [ADDR_W-1:0] VCO_CALIBRATION_CONFIG_ADDR   = 8'h0A;
  localparam logic [ADDR_W-1:0] PHASE_DETECTOR_CONTROL_ADDR   = 8'h0B;
  localparam logic [ADDR_W-1:0] EXACT_FREQUENCY_CHANNELS_ADDR = 8'h0C;

  // reset values
  localparam logic [DATA_W-1:0] VCO_CALIBRATION_CONFIG_RST   = 24'h002205;
  localparam logic [DATA_W-1:0] PHASE_DETECTOR_CONTROL_RST   = 24'h0F8061;
  localparam logic [DATA_W-1:0] EXACT_FREQUENCY_CHANNELS_RST = 24'h000000;

  // implemented bits per register, others read zero
  localparam logic [DATA_W-1:0] VCO_CALIBRATION_CONFIG_MASK   = 24'h01FFFF;
  localparam logic [DATA_W-1:0] PHASE_DETECTOR_CONTROL_MASK   = 24'hFFFFFF;
  localparam logic [DATA_W-1:0] EXACT_FREQUENCY_CHANNELS_MASK = 24'h003FFF;

  // calibration configuration fields
  localparam int unsigned VTUNE_RES_LSB    = 0;
  localparam int unsigned CURVE_ADJ_LSB    = 3;
  localparam int unsigned WAIT_SETUP_LSB   = 6;
  localparam int unsigned SAR_BITS_LSB     = 8;
  localparam int unsigned BYPASS_TUNE_BIT  = 11;
  localparam int unsigned NO_VSS_TRIG_BIT  = 12;
  localparam int unsigned CAL_CLK_SEL_LSB  = 13;
  localparam int unsigned XTAL_FALL_BIT    = 15;

  // phase detector control fields
  localparam int unsigned PFD_DELAY_LSB    = 0;
  localparam int unsigned PFD_SHORT_BIT    = 3;
  localparam int unsigned PFD_INVERT_BIT   = 4;
  localparam int unsigned PFD_UP_EN_BIT    = 5;
  localparam int unsigned PFD_DN_EN_BIT    = 6;
  localparam int unsigned CSP_LSB          = 7;
  localparam int unsigned CP_FORCE_UP_BIT  = 9;
  localparam int unsigned CP_FORCE_DN_BIT  = 10;
  localparam int unsigned CP_MID_RAIL_BIT  = 11;
  localparam int unsigned MDC_GATE_LSB     = 17;

  // timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned STARTUP_WAIT     = 100;
  localparam int unsigned CSP_T1_PS        = 5400;
  localparam int unsigned CSP_T2_PS        = 14400;
  localparam int unsigned CSP_T3_PS        = 24100;
  localparam int unsigned CSP_T1_CYC       = (CSP_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CSP_T2_CYC       = (CSP_T2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CSP_T3_CYC       = (CSP_T3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // divide limits for counter clock gating
  localparam logic [NDIV_W-1:0] MDC_LIMIT_SMALL = 19'd128;
  localparam logic [NDIV_W-1:0] MDC_LIMIT_MID   = 19'd1023;

  localparam logic [EXACT_W-1:0] EXACT_MIN_ON   = 14'h0002;

  typedef enum logic [1:0] {
    PAP_ST_IDLE = 2'b00,
    PAP_ST_WAIT = 2'b01,
    PAP_ST_MEAS = 2'b10,
    PAP_ST_DONE = 2'b11
  } pap_cal_state_t;

  // measurement length in reference divider cycles
  function automatic logic [8:0] pap_meas_cycles(input logic [2:0] code);
    case (code)
      3'h0:    pap_meas_cycles = 9'h001;
      3'h1:    pap_meas_cycles = 9'h002;
      3'h2:    pap_meas_cycles = 9'h004;
      3'h3:    pap_meas_cycles = 9'h008;
      3'h4:    pap_meas_cycles = 9'h020;
      3'h5:    pap_meas_cycles = 9'h040;
      3'h6:    pap_meas_cycles = 9'h080;
      default: pap_meas_cycles = 9'h100;
    endcase
  endfunction : pap_meas_cycles

  // search length in bits
  function automatic logic [3:0] pap_sar_bits(input logic [1:0] code);
    pap_sar_bits = 4'h8 - {2'b00, code};
  endfunction : pap_sar_bits

endpackage : pap_pkg

// ### core/pap_cal_if.sv
// pap_cal_if: link between the register top and the calibration sequencer
// assumes: single clock clk_sys, tick is a one-cycle enable
`timescale 1ns/1ps
interface pap_cal_if;
  import pap_pkg::*;
  logic               tick;
  logic [8:0]         meas_cycles;
  logic [1:0]         wait_code;
  logic [3:0]         sar_bits;
  logic [2:0]         curve_adj;
  logic               bypass;
  logic               start;
  logic               busy;
  logic               done;
  logic [CURVE_W-1:0] result;

  modport top (output tick, meas_cycles, wait_code, sar_bits, curve_adj, bypass, start,
               input busy, done, result);
  modport seq (input tick, meas_cycles, wait_code, sar_bits, curve_adj, bypass, start,
               output busy, done, result);
endinterface : pap_cal_if

// ### core/pap_cal_clk_div.sv
// pap_cal_clk_div: calibration clock enable from the crystal reference
// assumes: xtal_ref is synchronous to clk_sys and slower than clk_sys / 2
`timescale 1ns/1ps
module pap_cal_clk_div
  import pap_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       xtal_ref,
  input  wire logic [1:0] clk_sel,
  input  wire logic       fall_edge,
  output logic            tick
);

  logic       ref_q_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;
  logic       edge_seen;
  logic [4:0] last_cnt;

  always_comb begin
    edge_seen = fall_edge ? (ref_q_reg & ~xtal_ref) : (~ref_q_reg & xtal_ref); // [R8]
    case (clk_sel) // [R7]
      2'h0:    last_cnt = 5'h00;
      2'h1:    last_cnt = 5'h03;
      2'h2:    last_cnt = 5'h0F;
      default: last_cnt = 5'h1F;
    endcase
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (edge_seen) begin
      if (cnt_reg >= last_cnt) begin
        cnt_next  = 5'h00;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_q_reg <= 1'b0;
      cnt_reg   <= 5'h00;
      tick_reg  <= 1'b0;
    end else begin
      ref_q_reg <= xtal_ref;
      cnt_reg   <= cnt_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : pap_cal_clk_div

// ### core/pap_autocal_seq.sv
// pap_autocal_seq: vco curve search by successive approximation
// assumes: ref_div_tick pulses once per reference divider cycle
`timescale 1ns/1ps
module pap_autocal_seq
  import pap_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic ref_div_tick,
  input  wire logic vco_above_target,
  pap_cal_if.seq    cal
);

  pap_cal_state_t     state_reg;
  pap_cal_state_t     state_next;
  logic [6:0]         wait_reg;
  logic [6:0]         wait_next;
  logic [8:0]         meas_reg;
  logic [8:0]         meas_next;
  logic [3:0]         bit_reg;
  logic [3:0]         bit_next;
  logic [3:0]         mnum_reg;
  logic [3:0]         mnum_next;
  logic [CURVE_W-1:0] sar_reg;
  logic [CURVE_W-1:0] sar_next;
  logic [CURVE_W-1:0] res_reg;
  logic [CURVE_W-1:0] res_next;
  logic               done_reg;
  logic               done_next;
  logic [CURVE_W-1:0] trial;
  logic [9:0]         adj_sum;

  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    meas_next  = meas_reg;
    bit_next   = bit_reg;
    mnum_next  = mnum_reg;
    sar_next   = sar_reg;
    res_next   = res_reg;
    done_next  = 1'b0;
    trial      = sar_reg | (8'h01 << (bit_reg - 4'h1));
    adj_sum    = {2'b00, sar_reg} + {{7{cal.curve_adj[2]}}, cal.curve_adj}; // [R2]
    case (state_reg)
      PAP_ST_IDLE: begin
        if (cal.start) begin
          if (cal.bypass) begin // [R5]
            state_next = PAP_ST_DONE;
          end else begin
            state_next = PAP_ST_WAIT;
            wait_next  = 7'h00;
            bit_next   = cal.sar_bits; // [R4]
            mnum_next  = 4'h0;
            sar_next   = 8'h00;
          end
        end
      end
      PAP_ST_WAIT: begin
        if (cal.tick) begin
          if (wait_reg == 7'(STARTUP_WAIT - 1)) begin // [R3]
            state_next = PAP_ST_MEAS;
            meas_next  = 9'h000;
          end else begin
            wait_next = wait_reg + 7'h01;
          end
        end
      end
      PAP_ST_MEAS: begin
        if (ref_div_tick) begin
          if (meas_next == cal.meas_cycles - 9'h001 || meas_reg == cal.meas_cycles - 9'h001) begin // [R1]
            if (vco_above_target) begin
              sar_next = trial;
            end
            bit_next  = bit_reg - 4'h1;
            mnum_next = mnum_reg + 4'h1;
            meas_next = 9'h000;
            if (bit_reg == 4'h1) begin
              state_next = PAP_ST_DONE;
            end else if (mnum_reg < {2'b00, cal.wait_code}) begin // [R3]
              state_next = PAP_ST_WAIT;
              wait_next  = 7'h00;
            end
          end else begin
            meas_next = meas_reg + 9'h001;
          end
        end
      end
      PAP_ST_DONE: begin
        if (!cal.bypass) begin
          if (adj_sum[9]) begin
            res_next = 8'h00;
          end else if (adj_sum[8]) begin
            res_next = 8'hFF;
          end else begin
            res_next = adj_sum[7:0];
          end
        end
        done_next  = 1'b1;
        state_next = PAP_ST_IDLE;
      end
      default: state_next = PAP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= PAP_ST_IDLE;
      wait_reg  <= 7'h00;
      meas_reg  <= 9'h000;
      bit_reg   <= 4'h0;
      mnum_reg  <= 4'h0;
      sar_reg   <= 8'h00;
      res_reg   <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      meas_reg  <= meas_next;
      bit_reg   <= bit_next;
      mnum_reg  <= mnum_next;
      sar_reg   <= sar_next;
      res_reg   <= res_next;
      done_reg  <= done_next;
    end
  end

  assign cal.busy   = (state_reg != PAP_ST_IDLE);
  assign cal.done   = done_reg;
  assign cal.result = res_reg;

endmodule : pap_autocal_seq

// ### core/pap_config_regs.sv
// pap_config_regs: calibration, phase detector and exact frequency registers
// assumes: register port and all pin inputs synchronous to clk_sys
//
// Behaviour
// R1 - resolution code picks measurement length
// R2 - curve adjust offsets result, signed code
// R3 - hundred-tick wait at start, and after each of the first wait_code measurements only
// R4 - software keeps search bit code zero
// R5 - bypass clear means automatic calibration runs
// R6 - trigger disable blocks forwarded vco transfers
// R7 - calibration clock is reference divided
// R8 - edge select picks falling reference edge
// R9 - reset path delay select driven out
// R10 - short bit ties detector inputs together
// R11 - invert bit swaps detector polarity
// R12 - up and down outputs separately enabled
// R13 - slip prevention boosts beyond error threshold
// R14 - test bits force up, down, mid rail
// R15 - software programs reserved and bias fields
// R16 - counter clock gating by divide value
// R17 - software programs upper reserved fields zero
// R18 - channel count two or more enables mode
// R19 - exact mode modulus given to modulator
// R20 - fields reset, update on write, read back
`timescale 1ns/1ps
module pap_config_regs
  import pap_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  output logic      [DATA_W-1:0]  reg_rdata,
  output logic                    reg_rvalid,
  input  wire logic               xtal_ref,
  input  wire logic               ref_div_tick,
  input  wire logic               vco_above_target,
  input  wire logic               cal_start,
  output logic                    cal_busy,
  output logic                    cal_done,
  output logic      [CURVE_W-1:0] vco_curve,
  output logic                    cal_clk_tick,
  input  wire logic               vco_xfer_req,
  output logic                    vco_xfer_fwd,
  input  wire logic               pfd_ref_in,
  input  wire logic               pfd_div_in,
  output logic                    pfd_up,
  output logic                    pfd_down,
  output logic      [2:0]         pfd_reset_delay_select,
  output logic                    csp_boost,
  output logic                    cp_force_up,
  output logic                    cp_force_down,
  output logic                    cp_mid_rail,
  input  wire logic [NDIV_W-1:0]  main_divide_value,
  output logic                    main_divide_counter_clk_en,
  output logic                    exact_freq_enable,
  output logic      [EXACT_W-1:0] exact_modulus
);

  logic [DATA_W-1:0]  cal_cfg_reg;
  logic [DATA_W-1:0]  cal_cfg_next;
  logic [DATA_W-1:0]  pfd_ctl_reg;
  logic [DATA_W-1:0]  pfd_ctl_next;
  logic [DATA_W-1:0]  exact_reg;
  logic [DATA_W-1:0]  exact_next;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  rdata_next;
  logic               rvalid_reg;
  logic               rvalid_next;
  logic               fwd_reg;
  logic               fwd_next;
  logic               ref_q_reg;
  logic               div_q_reg;
  logic               up_reg;
  logic               up_next;
  logic               dn_reg;
  logic               dn_next;
  logic [3:0]         err_reg;
  logic [3:0]         err_next;
  logic               boost_reg;
  logic               boost_next;
  logic               gate_reg;
  logic               gate_next;
  logic               exen_reg;
  logic               exen_next;
  logic [EXACT_W-1:0] exmod_reg;
  logic [EXACT_W-1:0] exmod_next;
  logic               det_b;
  logic               ref_rise;
  logic               div_rise;
  logic [3:0]         csp_limit;
  logic [1:0]         csp_code;
  logic [1:0]         gate_code;
  logic [EXACT_W-1:0] chan;
  logic               cal_tick;

  pap_cal_if cal_bus ();

  pap_cal_clk_div u_clk_div (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .xtal_ref  (xtal_ref),
    .clk_sel   (cal_cfg_reg[CAL_CLK_SEL_LSB +: 2]),
    .fall_edge (cal_cfg_reg[XTAL_FALL_BIT]),
    .tick      (cal_tick)
  );

  pap_autocal_seq u_autocal (
    .clk_sys          (clk_sys),
    .rstn             (rstn),
    .ref_div_tick     (ref_div_tick),
    .vco_above_target (vco_above_target),
    .cal              (cal_bus.seq)
  );

  // calibration configuration to the sequencer
  assign cal_bus.tick        = cal_tick; // [R7]
  assign cal_bus.meas_cycles = pap_meas_cycles(cal_cfg_reg[VTUNE_RES_LSB +: 3]); // [R1]
  assign cal_bus.wait_code   = cal_cfg_reg[WAIT_SETUP_LSB +: 2]; // [R3]
  assign cal_bus.sar_bits    = pap_sar_bits(cal_cfg_reg[SAR_BITS_LSB +: 2]); // [R4]
  assign cal_bus.curve_adj   = cal_cfg_reg[CURVE_ADJ_LSB +: 3]; // [R2]
  assign cal_bus.bypass      = cal_cfg_reg[BYPASS_TUNE_BIT]; // [R5]
  assign cal_bus.start       = cal_start;

  // register port
  always_comb begin
    cal_cfg_next = cal_cfg_reg;
    pfd_ctl_next = pfd_ctl_reg;
    exact_next   = exact_reg;
    rdata_next   = rdata_reg;
    rvalid_next  = 1'b0;
    if (reg_wr) begin // [R20]
      case (reg_addr)
        VCO_CALIBRATION_CONFIG_ADDR:   cal_cfg_next = reg_wdata & VCO_CALIBRATION_CONFIG_MASK;
        PHASE_DETECTOR_CONTROL_ADDR:   pfd_ctl_next = reg_wdata & PHASE_DETECTOR_CONTROL_MASK;
        EXACT_FREQUENCY_CHANNELS_ADDR: exact_next = reg_wdata & EXACT_FREQUENCY_CHANNELS_MASK;
        default: ;
      endcase
    end
    if (reg_rd) begin // [R20]
      rvalid_next = 1'b1;
      case (reg_addr)
        VCO_CALIBRATION_CONFIG_ADDR:   rdata_next = cal_cfg_reg;
        PHASE_DETECTOR_CONTROL_ADDR:   rdata_next = pfd_ctl_reg;
        EXACT_FREQUENCY_CHANNELS_ADDR: rdata_next = exact_reg;
        default:                       rdata_next = 24'h000000;
      endcase
    end
  end

  // vco transfer forwarding
  always_comb begin
    fwd_next = vco_xfer_req & ~cal_cfg_reg[NO_VSS_TRIG_BIT]; // [R6]
  end

  // phase frequency detector with slip prevention
  always_comb begin
    det_b      = pfd_ctl_reg[PFD_SHORT_BIT] ? pfd_ref_in : pfd_div_in; // [R10]
    ref_rise   = pfd_ref_in & ~ref_q_reg;
    div_rise   = det_b & ~div_q_reg;
    up_next    = up_reg | ref_rise;
    dn_next    = dn_reg | div_rise;
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    csp_code = pfd_ctl_reg[CSP_LSB +: 2];
    case (csp_code) // [R13]
      2'h1:    csp_limit = 4'(CSP_T1_CYC);
      2'h2:    csp_limit = 4'(CSP_T2_CYC);
      default: csp_limit = 4'(CSP_T3_CYC);
    endcase
    err_next   = (up_reg ^ dn_reg) ? ((err_reg == 4'hF) ? err_reg : err_reg + 4'h1) : 4'h0;
    boost_next = (csp_code != 2'h0) && (up_reg ^ dn_reg) && (err_reg >= csp_limit); // [R13]
  end

  // counter clock gating and exact frequency mode
  always_comb begin
    gate_code = pfd_ctl_reg[MDC_GATE_LSB +: 2];
    case (gate_code) // [R16]
      2'h0:    gate_next = 1'b0;
      2'h1:    gate_next = main_divide_value < MDC_LIMIT_SMALL;
      2'h2:    gate_next = main_divide_value < MDC_LIMIT_MID;
      default: gate_next = 1'b1;
    endcase
    chan       = exact_reg[EXACT_W-1:0];
    exen_next  = chan >= EXACT_MIN_ON; // [R18]
    exmod_next = exen_next ? chan : 14'h0000; // [R19]
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cal_cfg_reg <= VCO_CALIBRATION_CONFIG_RST; // [R20]
      pfd_ctl_reg <= PHASE_DETECTOR_CONTROL_RST;
      exact_reg   <= EXACT_FREQUENCY_CHANNELS_RST;
      rdata_reg   <= 24'h000000;
      rvalid_reg  <= 1'b0;
      fwd_reg     <= 1'b0;
      ref_q_reg   <= 1'b0;
      div_q_reg   <= 1'b0;
      up_reg      <= 1'b0;
      dn_reg      <= 1'b0;
      err_reg     <= 4'h0;
      boost_reg   <= 1'b0;
      gate_reg    <= 1'b0;
      exen_reg    <= 1'b0;
      exmod_reg   <= 14'h0000;
    end else begin
      cal_cfg_reg <= cal_cfg_next;
      pfd_ctl_reg <= pfd_ctl_next;
      exact_reg   <= exact_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      fwd_reg     <= fwd_next;
      ref_q_reg   <= pfd_ref_in;
      div_q_reg   <= det_b;
      up_reg      <= up_next;
      dn_reg      <= dn_next;
      err_reg     <= err_next;
      boost_reg   <= boost_next;
      gate_reg    <= gate_next;
      exen_reg    <= exen_next;
      exmod_reg   <= exmod_next;
    end
  end

  // detector outputs with polarity swap and enables
  assign pfd_up   = pfd_ctl_reg[PFD_UP_EN_BIT] &
                    (pfd_ctl_reg[PFD_INVERT_BIT] ? dn_reg : up_reg); // [R11] [R12]
  assign pfd_down = pfd_ctl_reg[PFD_DN_EN_BIT] &
                    (pfd_ctl_reg[PFD_INVERT_BIT] ? up_reg : dn_reg); // [R11] [R12]

  assign pfd_reset_delay_select     = pfd_ctl_reg[PFD_DELAY_LSB +: 3]; // [R9]
  assign cp_force_up                = pfd_ctl_reg[CP_FORCE_UP_BIT]; // [R14]
  assign cp_force_down              = pfd_ctl_reg[CP_FORCE_DN_BIT]; // [R14]
  assign cp_mid_rail                = pfd_ctl_reg[CP_MID_RAIL_BIT]; // [R14]
  assign csp_boost                  = boost_reg;
  assign main_divide_counter_clk_en = gate_reg;
  assign exact_freq_enable          = exen_reg;
  assign exact_modulus              = exmod_reg;
  assign vco_xfer_fwd               = fwd_reg;
  assign reg_rdata                  = rdata_reg;
  assign reg_rvalid                 = rvalid_reg;
  assign cal_busy                   = cal_bus.busy;
  assign cal_done                   = cal_bus.done;
  assign vco_curve                  = cal_bus.result;
  assign cal_clk_tick               = cal_tick;

endmodule : pap_config_regs

// ### testbench/pap_chk.sv
// pap_chk: concurrent checks on the configuration register top ports
// assumes: bound to pap_config_regs, one clock clk_sys
`timescale 1ns/1ps
module pap_chk
  import pap_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_rvalid,
  input wire logic               cal_start,
  input wire logic               cal_busy,
  input wire logic               cal_done,
  input wire logic               cal_clk_tick,
  input wire logic               vco_xfer_req,
  input wire logic               vco_xfer_fwd,
  input wire logic [2:0]         pfd_reset_delay_select,
  input wire logic               cp_force_up,
  input wire logic               exact_freq_enable,
  input wire logic [EXACT_W-1:0] exact_modulus,
  input wire logic               main_divide_counter_clk_en
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without read");
  delay_field_a: assert property (
    reg_wr && reg_addr == 8'h0B |=> pfd_reset_delay_select == $past(reg_wdata[2:0]))
    else $error("delay select not updated");
  force_up_a: assert property (
    reg_wr && reg_addr == 8'h0B |=> cp_force_up == $past(reg_wdata[9]))
    else $error("force up not updated");
  exact_on_a: assert property (exact_freq_enable |-> exact_modulus >= 14'h0002)
    else $error("exact mode on with small count");
  exact_off_a: assert property (!exact_freq_enable |-> exact_modulus == 14'h0000)
    else $error("modulus given while exact mode off");
  cal_take_a: assert property (cal_start && !cal_busy |=> cal_busy)
    else $error("calibration start not taken");
  done_pulse_a: assert property (cal_done |-> !cal_busy ##1 !cal_done)
    else $error("calibration done not a pulse");
  tick_pulse_a: assert property (cal_clk_tick |=> !cal_clk_tick)
    else $error("calibration tick not a pulse");
  fwd_cause_a: assert property (vco_xfer_fwd |-> $past(vco_xfer_req))
    else $error("transfer forwarded without request");
  gate_off_a: assert property (
    reg_wr && reg_addr == 8'h0B && reg_wdata[18:17] == 2'h0 ##1 !reg_wr
    |=> !main_divide_counter_clk_en)
    else $error("counter clock not gated off");

  cover property (cal_done);
  cover property ($rose(exact_freq_enable));
  cover property (cal_clk_tick);
endmodule : pap_chk

bind pap_config_regs pap_chk u_chk (.*);

// ### testbench/tb.sv
// tb: self-checking bench for the configuration registers
// assumes: all pins driven at the falling edge of clk_sys
`timescale 1ns/1ps
module tb;
  import pap_pkg::*;
  logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, xtal_ref = 0;
  logic ref_div_tick = 0, vco_above_target = 0, cal_start = 0, vco_xfer_req = 0;
  logic pfd_ref_in = 0, pfd_div_in = 0, reg_rvalid, cal_busy, cal_done, cal_clk_tick;
  logic vco_xfer_fwd, pfd_up, pfd_down, csp_boost, cp_force_up, cp_force_down;
  logic cp_mid_rail, main_divide_counter_clk_en, exact_freq_enable;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 24'h000000;
  logic [DATA_W-1:0] reg_rdata;
  logic [CURVE_W-1:0] vco_curve;
  logic [2:0] pfd_reset_delay_select;
  logic [NDIV_W-1:0] main_divide_value = 19'h000C8;
  logic [EXACT_W-1:0] exact_modulus;
  int fail_count = 0;
  int n_tests = 0;

  pap_config_regs DUT (.*);

  initial forever #2.5 clk_sys = ~clk_sys;
  always #10 xtal_ref = ~xtal_ref;

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic wr(logic [7:0] a, logic [23:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 0;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [23:0] exp);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 0;
    check("rvalid", reg_rvalid, 1);
    check("rdata", reg_rdata, exp);
    @(negedge clk_sys);
  endtask : rd

  task automatic pfd(logic [23:0] d, logic eu, logic ed, logic ec);
    wr(8'h0B, d);
    pfd_ref_in = 1;
    repeat (8) @(negedge clk_sys);
    check("up", pfd_up, eu);
    check("down", pfd_down, ed);
    check("boost", csp_boost, ec);
    pfd_div_in = 1;
    repeat (3) @(negedge clk_sys);
    pfd_ref_in = 0;
    pfd_div_in = 0;
    repeat (2) @(negedge clk_sys);
  endtask : pfd

  initial begin
    logic [23:0] wv [4] = '{24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF, 24'h123456};
    logic [23:0] rv [4] = '{24'h01FFFF, 24'hFFFFFF, 24'h003FFF, 24'h000000};
    logic [13:0] ex [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3FFF};
    int n;
    repeat (5) @(negedge clk_sys);
    rstn = 1;
    @(negedge clk_sys);
    rd(8'h0A, 24'h002205);
    rd(8'h0B, 24'h0F8061);
    rd(8'h0C, 24'h000000);
    check("delay", pfd_reset_delay_select, 1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0A + i[7:0], wv[i]);
      rd(8'h0A + i[7:0], rv[i]);
    end
    check("forces", {cp_force_up, cp_force_down, cp_mid_rail}, 3'h7);
    check("delay", pfd_reset_delay_select, 7);
    wr(8'h0B, 24'h000000);
    check("forces", {cp_force_up, cp_force_down, cp_mid_rail}, 3'h0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0C, {10'h000, ex[c]});
      check("exact en", exact_freq_enable, c > 1);
      check("modulus", exact_modulus, (c > 1) ? ex[c] : 14'h0000);
      wr(8'h0B, 24'h09C061 | (c << 17));
      check("mclk en", main_divide_counter_clk_en, c > 1);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h0A, 24'h000205 | (c << 13));
      repeat (160) @(negedge clk_sys);
      n = 0;
      repeat (640) begin
        @(negedge clk_sys);
        n += cal_clk_tick;
      end
      check("ticks", n, 160 >> (c == 0 ? 0 : c == 1 ? 2 : c == 2 ? 4 : 5));
    end
    wr(8'h0A, 24'h003205);
    vco_xfer_req = 1;
    repeat (2) @(negedge clk_sys);
    check("fwd off", vco_xfer_fwd, 0);
    wr(8'h0A, 24'h002205);
    check("fwd on", vco_xfer_fwd, 1);
    vco_xfer_req = 0;
    pfd(24'h0F8061, 1, 0, 0);
    pfd(24'h0F8071, 0, 1, 0);
    pfd(24'h0F8041, 0, 0, 0);
    pfd(24'h0F8069, 0, 0, 0);
    pfd(24'h0F81E1, 1, 0, 1);
    pfd(24'h0F80E1, 1, 0, 1);
    pfd(24'h0F8161, 1, 0, 1);
    wr(8'h0A, 24'h002A05);
    cal_start = 1;
    @(negedge clk_sys);
    cal_start = 0;
    n = 1;
    while (cal_done !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    check("done time", n, 2);
    check("curve", vco_curve, 0);
    for (int e = 0; e < 2; e++) begin
      @(negedge clk_sys);
      wr(8'h0A, 24'h000078 | (e << 15));
      n = 0;
      repeat (8) begin
        @(posedge clk_sys);
        #1 n += int'(cal_clk_tick & (xtal_ref ^ e[0]));
      end
      check("edge ticks", n, 2);
    end
    @(negedge clk_sys);
    ref_div_tick = 1;
    vco_above_target = 1;
    cal_start = 1;
    @(negedge clk_sys);
    cal_start = 0;
    n = 1;
    while (cal_done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    ref_div_tick = 0;
    vco_above_target = 0;
    check("cal time", n > 800 && n < 815, 1);
    check("cal curve", vco_curve, 8'hFE);
    final_report();
  end
endmodule : tb
